/* verilog/ims_master.sv */
// i2c master sequencer: apb registers, rate counter, start/restart/stop and byte transmit
`timescale 1ns/100ps
`default_nettype none

module ims_master import ims_pkg::*; #(
    parameter int PDIV = PHASE_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    // synchronisers for the bus lines
    logic scl_m, scl_s, sda_m, sda_s;
    // q2/q4 phase divider
    logic [7:0] pdiv;
    logic q_tick;
    // rate counter
    logic [6:0] cnt;
    logic cnt_run;
    logic load_req;
    logic to;
    // sequencer
    ims_state_t state;
    logic armed;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic ackstat;
    // software visible registers
    logic [7:0] shift_buffer;
    logic [6:0] reload;
    logic [7:0] ctrl2;
    logic buf_full, start_det, stop_det;
    logic [2:0] flags;
    // bus decode
    logic apb_setup, apb_wr, hit;
    logic [31:0] rdata;
    // events
    logic idle, buf_wr, buf_ok, write_collision_flag_ev, bcl_st, bcl_rs, bcl_ev;
    logic start_ok, rs_ok, tx_done, sp_ok, sp_det, det_ev, bf_clr, irq_ev;

    // two flops before any logic reads the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            sda_m <= sda_in;
            sda_s <= sda_m;
        end
    end

    // open-drain lines only ever pull low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    // phase tick: two per instruction cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pdiv <= 8'h00;
            q_tick <= 1'b0;
        end else if (pdiv == 8'(PDIV - 1)) begin
            pdiv <= 8'h00;
            q_tick <= 1'b1;
        end else begin
            pdiv <= pdiv + 8'h01;
            q_tick <= 1'b0;
        end
    end

    // timeout when a running count is at zero on a phase tick
    assign to = cnt_run & q_tick & (cnt == 7'h00) & ~load_req;

    // rate counter: reload, count down, stop at zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 7'h00;
            cnt_run <= 1'b0;
        end else if (load_req) begin
            cnt <= reload;
            cnt_run <= 1'b1;
        end else if (to) begin
            cnt_run <= 1'b0;
        end else if (cnt_run && q_tick) begin
            cnt <= cnt - 7'h01;
        end
    end

    // event decode
    assign idle = (state == S_IDLE);
    assign buf_wr = apb_wr & (paddr == ADDR_BUF);
    assign buf_ok = buf_wr & idle;
    // writes during start, restart, stop or a byte collide
    assign write_collision_flag_ev = buf_wr & ~idle;
    // start collision: both low at begin, scl low early, sda low at timeout
    assign bcl_st = (idle & ctrl2[C2_START] & ~scl_s & ~sda_s)
        | ((state == S_ST_WAIT) & (~scl_s | (to & ~sda_s)));
    // restart collision: sda not high, sda low at scl rise, scl low early
    assign bcl_rs = ((state == S_RS_LOW) & armed & to & ~sda_s)
        | ((state == S_RS_SCLHI) & ~armed & scl_s & ~sda_s)
        | ((state == S_RS_SCLHI) & armed & ~scl_s);
    assign bcl_ev = bcl_st | bcl_rs;
    assign start_ok = (state == S_ST_HOLD) & to;
    assign rs_ok = (state == S_RS_SDALO) & to;
    assign tx_done = (state == S_TX_HIGH) & armed & to & (bitn == ACK_BIT);
    assign bf_clr = (state == S_TX_HIGH) & armed & to & (bitn == 4'h7);
    assign sp_det = (state == S_SP_SDAHI) & ~armed & scl_s & sda_s;
    assign sp_ok = (state == S_SP_SDAHI) & armed & to;
    // start seen on the lines: sda falls while scl high
    assign det_ev = ((state == S_ST_WAIT) & to & scl_s & sda_s)
        | ((state == S_RS_SDALO) & scl_s & ~sda_s);
    // port flag only after the rate counter timed out
    assign irq_ev = start_ok | rs_ok | tx_done | sp_ok;

    // sequencer: owns the line drivers and counter reloads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            armed <= 1'b0;
            load_req <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            bitn <= 4'h0;
            shreg <= 8'h00;
            ackstat <= 1'b0;
        end else begin
            load_req <= 1'b0;
            if (bcl_ev) begin
                // abort: let both lines go, back to idle
                state <= S_IDLE;
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    S_IDLE: begin
                        // lines stay as left by the last event
                        if (ctrl2[C2_START]) begin
                            if (scl_s && sda_s) begin
                                load_req <= 1'b1;
                                state <= S_ST_WAIT;
                            end
                        end else if (ctrl2[C2_RESTART]) begin
                            scl_oe <= 1'b1;
                            armed <= 1'b0;
                            state <= S_RS_LOW;
                        end else if (ctrl2[C2_STOP]) begin
                            sda_oe <= 1'b1;
                            armed <= 1'b0;
                            state <= S_SP_SDALO;
                        end else if (buf_ok) begin
                            // first bit out with scl low
                            shreg <= pwdata[7:0];
                            bitn <= 4'h0;
                            scl_oe <= 1'b1;
                            // sda follows one pclk after scl has fallen
                            armed <= 1'b0;
                            load_req <= 1'b1;
                            state <= S_TX_LOW;
                        end
                    end
                    S_ST_WAIT: begin
                        // both still high at timeout: pull sda low
                        if (to) begin
                            sda_oe <= 1'b1;
                            load_req <= 1'b1;
                            state <= S_ST_HOLD;
                        end
                    end
                    S_ST_HOLD: begin
                        // hold sda low, counter runs down to its timeout
                        if (to) begin
                            state <= S_IDLE;
                        end
                    end
                    S_RS_LOW: begin
                        // scl seen low: release sda for one rollover
                        if (!armed && !scl_s) begin
                            load_req <= 1'b1;
                            armed <= 1'b1;
                            sda_oe <= 1'b0;
                        end else if (armed && to) begin
                            scl_oe <= 1'b0;
                            armed <= 1'b0;
                            state <= S_RS_SCLHI;
                        end
                    end
                    S_RS_SCLHI: begin
                        // wait for scl high, then one rollover with both high
                        if (!armed && scl_s) begin
                            load_req <= 1'b1;
                            armed <= 1'b1;
                        end else if (armed && to) begin
                            sda_oe <= 1'b1;
                            load_req <= 1'b1;
                            state <= S_RS_SDALO;
                        end
                    end
                    S_RS_SDALO: begin
                        // no reload after this timeout, sda stays low
                        if (to) begin
                            state <= S_IDLE;
                        end
                    end
                    S_TX_LOW: begin
                        // scl low phase: sda never changes in the pclk where scl falls
                        if (!armed) begin
                            // ninth bit: sda released for the acknowledge
                            sda_oe <= (bitn == ACK_BIT) ? 1'b0 : ~shreg[7];
                            armed <= 1'b1;
                        end else if (to) begin
                            scl_oe <= 1'b0;
                            armed <= 1'b0;
                            state <= S_TX_HIGH;
                        end
                    end
                    S_TX_HIGH: begin
                        // high time counts only once scl is really high
                        if (!armed && scl_s) begin
                            load_req <= 1'b1;
                            armed <= 1'b1;
                        end else if (armed && to) begin
                            scl_oe <= 1'b1;
                            if (bitn == ACK_BIT) begin
                                // ninth clock: keep the acknowledge, scl low
                                ackstat <= sda_s;
                                sda_oe <= 1'b0;
                                state <= S_IDLE;
                            end else begin
                                bitn <= bitn + 4'h1;
                                shreg <= {shreg[6:0], 1'b0};
                                // next bit goes out once scl is low
                                armed <= 1'b0;
                                load_req <= 1'b1;
                                state <= S_TX_LOW;
                            end
                        end
                    end
                    S_SP_SDALO: begin
                        // sda seen low: one rollover, then release scl
                        if (!armed && !sda_s) begin
                            load_req <= 1'b1;
                            armed <= 1'b1;
                        end else if (armed && to) begin
                            scl_oe <= 1'b0;
                            armed <= 1'b0;
                            state <= S_SP_SCLHI;
                        end
                    end
                    S_SP_SCLHI: begin
                        // scl seen high: one rollover, then release sda
                        if (!armed && scl_s) begin
                            load_req <= 1'b1;
                            armed <= 1'b1;
                        end else if (armed && to) begin
                            sda_oe <= 1'b0;
                            armed <= 1'b0;
                            state <= S_SP_SDAHI;
                        end
                    end
                    S_SP_SDAHI: begin
                        // both high: stop seen, one more rollover
                        if (sp_det) begin
                            load_req <= 1'b1;
                            armed <= 1'b1;
                        end else if (sp_ok) begin
                            state <= S_IDLE;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                        scl_oe <= 1'b0;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // control and data registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_buffer <= BUF_RST;
            reload <= RELOAD_RST;
            ctrl2 <= CTRL2_RST;
        end else begin
            if (buf_ok) begin
                shift_buffer <= pwdata[7:0];
            end
            if (apb_wr && paddr == ADDR_RELOAD) begin
                reload <= pwdata[6:0];
            end
            if (apb_wr && paddr == ADDR_CTRL2) begin
                // upper bits always, request bits only while idle
                ctrl2[7:C2_REQ_W] <= pwdata[7:C2_REQ_W];
                if (idle) begin
                    ctrl2[C2_REQ_W-1:0] <= pwdata[C2_REQ_W-1:0];
                end
            end
            // hardware clears requests when their sequence ends, even over a write
            if (start_ok || bcl_st) begin
                ctrl2[C2_START] <= 1'b0;
            end
            if (rs_ok || bcl_rs) begin
                ctrl2[C2_RESTART] <= 1'b0;
            end
            if (sp_ok) begin
                ctrl2[C2_STOP] <= 1'b0;
            end
        end
    end

    // port state bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_full <= 1'b0;
            start_det <= 1'b0;
            stop_det <= 1'b0;
        end else begin
            if (buf_ok) begin
                buf_full <= 1'b1;
            end else if (bf_clr) begin
                buf_full <= 1'b0;
            end
            if (det_ev) begin
                start_det <= 1'b1;
                stop_det <= 1'b0;
            end else if (sp_det) begin
                stop_det <= 1'b1;
                start_det <= 1'b0;
            end
        end
    end

    // sticky flags, write one to clear, a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= 3'h0;
        end else begin
            flags <= (flags & ~((apb_wr && paddr == ADDR_FLAGS) ? pwdata[2:0] : 3'h0))
                | {write_collision_flag_ev, bcl_ev, irq_ev};
        end
    end

    // apb decode and read mux
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pready & pwrite;
    always_comb begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            ADDR_BUF: rdata = {24'h000000, shift_buffer};
            ADDR_RELOAD: rdata = {25'h0000000, reload};
            ADDR_CTRL2: rdata = {24'h000000, ctrl2[7], ackstat, ctrl2[5:0]};
            ADDR_STATE: rdata = {27'h0000000, stop_det, start_det, 2'h0, buf_full};
            ADDR_FLAGS: rdata = {29'h00000000, flags};
            default: hit = 1'b0;
        endcase
    end

    // zero-wait slave: answer registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~hit;
            prdata <= (apb_setup && !pwrite) ? rdata : 32'h0000_0000;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PREADY: assert property (apb_setup |=> pready ##1 !pready || apb_setup)
        else $error("pready not one cycle after setup");
    AST_WRITE_COLLISION_FLAG: assert property (buf_wr && !idle |=> flags[FL_WRITE_COLLISION_FLAG] && $stable(shift_buffer))
        else $error("busy buffer write not refused");
    AST_CTRL_LOCK: assert property (apb_wr && paddr == ADDR_CTRL2 && !idle
        |=> (ctrl2[4:0] & ~$past(ctrl2[4:0])) == 5'h00)
        else $error("request bit set while busy");
    AST_RELOAD: assert property (load_req |=> cnt_run && cnt == $past(reload))
        else $error("counter not loaded from reload");
    AST_STEP: assert property (cnt_run && !q_tick && !load_req |=> $stable(cnt))
        else $error("counter moved off a phase tick");
    AST_ARB: assert property (state == S_TX_HIGH && !scl_s && !armed |=> !cnt_run)
        else $error("high time counted with scl low");
    AST_START: assert property (state == S_ST_HOLD && to
        |=> idle && sda_oe && !ctrl2[C2_START] && flags[FL_IRQ] && start_det)
        else $error("start not completed");
    AST_START_BCL: assert property (state == S_ST_WAIT && !scl_s
        |=> idle && flags[FL_BCL] && !ctrl2[C2_START] && !sda_oe)
        else $error("start collision missed");
    AST_RS_IDLE: assert property ($rose(state == S_RS_LOW) |-> $past(state) == S_IDLE)
        else $error("restart began outside idle");
    AST_IRQ: assert property ($rose(flags[FL_IRQ]) |-> $past(to))
        else $error("port flag without timeout");
    AST_ACK: assert property (tx_done |=> ackstat == $past(sda_s) && scl_oe && !cnt_run)
        else $error("ack not stored or clock not held");
    CVR_START: cover property (start_ok);
    CVR_BYTE: cover property (tx_done);
    CVR_STOP: cover property (sp_ok);
    CVR_RESTART: cover property (rs_ok);
    CVR_BCL: cover property (bcl_ev);
endmodule
`default_nettype wire

/* verilog/ims_pkg.sv */
// package of register map, field positions, timing and state codes for the i2c master sequencer
package ims_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADDR_BUF = 8'h00;
    localparam logic [7:0] ADDR_RELOAD = 8'h04;
    localparam logic [7:0] ADDR_CTRL2 = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0c;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    // second control register fields
    localparam int C2_START = 0;
    localparam int C2_RESTART = 1;
    localparam int C2_STOP = 2;
    localparam int C2_ACKSTAT = 6;
    localparam int C2_REQ_W = 5;
    // port state register fields
    localparam int ST_FULL = 0;
    localparam int ST_STARTDET = 3;
    localparam int ST_STOPDET = 4;
    // sticky flag register fields
    localparam int FL_IRQ = 0;
    localparam int FL_BCL = 1;
    localparam int FL_WRITE_COLLISION_FLAG = 2;
    // reset values
    localparam logic [6:0] RELOAD_RST = 7'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] BUF_RST = 8'h00;
    // timing: pclk rate and the q2/q4 phase rate (twice the instruction rate)
    localparam int PCLK_MHZ = 100;
    localparam int PHASE_MHZ = 20;
    localparam int PHASE_DIV = PCLK_MHZ / PHASE_MHZ;
    // the ninth clock of a byte carries the acknowledge
    localparam logic [3:0] ACK_BIT = 4'h8;
    // sequencer states, one-hot
    typedef enum logic [11:0] {
        S_IDLE = 12'h001,
        S_ST_WAIT = 12'h002,
        S_ST_HOLD = 12'h004,
        S_RS_LOW = 12'h008,
        S_RS_SDAHI = 12'h010,
        S_RS_SCLHI = 12'h020,
        S_RS_SDALO = 12'h040,
        S_TX_LOW = 12'h080,
        S_TX_HIGH = 12'h100,
        S_SP_SDALO = 12'h200,
        S_SP_SCLHI = 12'h400,
        S_SP_SDAHI = 12'h800
    } ims_state_t;
endpackage

/* tb/ims_slave.sv */
// i2c slave partner model: acknowledges bytes and records them
`timescale 1ns/100ps
`default_nettype none
module ims_slave (
    input wire logic pclk,
    input wire logic scl,
    input wire logic sda,
    input wire logic nack,
    output logic sda_pull
);
    logic scl_d = 1'b1; // previous scl
    logic sda_d = 1'b1; // previous sda
    logic ack_ph = 1'b0; // in the ninth clock
    int cnt = 0; // bits of the byte seen
    logic [7:0] sh = 8'h00; // shift register
    logic [7:0] got [$]; // bytes received
    initial sda_pull = 1'b0;
    // bits taken on scl rise msb first, ack driven on the ninth low phase
    always @(posedge pclk) begin
        scl_d <= scl;
        sda_d <= sda;
        if (scl && scl_d && sda_d && !sda) begin // start or restart
            cnt <= 0;
            ack_ph <= 1'b0;
        end else if (scl && !scl_d && cnt < 8) begin
            sh <= {sh[6:0], sda};
            cnt <= cnt + 1;
            if (cnt == 7) got.push_back({sh[6:0], sda});
        end else if (!scl && scl_d && cnt == 8) begin
            sda_pull <= !ack_ph && !nack;
            ack_ph <= !ack_ph;
            if (ack_ph) cnt <= 0;
        end
    end
endmodule
`default_nettype wire

/* tb/i2c_master_sequencer_test.sv */
// testbench of the i2c master sequencer against a slave model
`timescale 1ns/100ps
`default_nettype none
module i2c_master_sequencer_test import ims_pkg::*;;
    logic pclk = 1'b0; // apb clock
    logic presetn = 1'b0; // reset, active low
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic scl_oe, sda_oe, s_pull, nack = 1'b0, tb_sda = 1'b0; // line pulls
    logic tb_scl = 1'b0; // another device holding scl low
    logic scl_o, sda_o; // open-drain data outputs, always low
    localparam int PD = 2; // pclk per phase tick in this bench
    logic scl_q = 1'b1; // previous scl
    int fails = 0, cmp_count = 0, tick = 0, per = 0, seed = 32'hbc3e;
    logic [6:0] rl; // reload chosen
    logic [7:0] b; // byte sent
    logic [7:0] exp_q [$]; // expected bytes on the wire
    wire scl = ~(scl_oe | tb_scl); // wired-and with pull-up
    wire sda = ~(sda_oe | s_pull | tb_sda);
    always #5 pclk = ~pclk;
    ims_master #(.PDIV(PD)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_o),
        .sda_oe(sda_oe));
    ims_slave slv (.pclk(pclk), .scl(scl), .sda(sda), .nack(nack), .sda_pull(s_pull));
    // scl period between rising edges
    always @(posedge pclk) begin
        scl_q <= scl;
        tick <= (scl && !scl_q) ? 1 : tick + 1;
        if (scl && !scl_q) per <= tick;
    end
    task automatic results;
        $display("Compared %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one apb transfer, waits for pready, idles a cycle after
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // poll flags for a bit, then clear it
    task automatic wait_flag(input logic [31:0] m);
        rd = 32'h0;
        for (int i = 0; i < 600 && (rd & m) !== m; i++) apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd & m, m);
        apb(1'b1, ADDR_FLAGS, m);
    endtask
    // send one byte and check its wire image, ack and period
    task automatic send(input logic [7:0] v, input logic nk);
        nack <= nk;
        exp_q.push_back(v);
        apb(1'b1, ADDR_BUF, {24'h0, v});
        wait_flag(32'h1);
        chk(per >= 2 * (rl + 1) * PD && per <= 2 * (rl + 1) * PD + 10, 1);
        chk(slv.got.pop_front(), exp_q.pop_front());
        apb(1'b0, ADDR_CTRL2, 32'h0);
        chk(rd & 32'h40, nk ? 32'h40 : 32'h0);
        chk(scl, 0);
    endtask
    initial begin
        #400000;
        fails++;
        results;
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_CTRL2, 32'h0);
        chk(rd, CTRL2_RST);
        apb(1'b0, 8'h14, 32'h0);
        chk(er, 1);
        chk(rd, 0);
        rl = 7'h10 + 7'($random(seed) & 7);
        apb(1'b1, ADDR_RELOAD, {24'h0, 1'b1, rl});
        apb(1'b0, ADDR_RELOAD, 32'h0);
        chk(rd, rl);
        apb(1'b1, ADDR_CTRL2, 32'h1);
        apb(1'b1, ADDR_BUF, 32'h5a);
        apb(1'b1, ADDR_CTRL2, 32'h7);
        apb(1'b0, ADDR_CTRL2, 32'h0);
        chk(rd & 32'h1f, 32'h1);
        wait_flag(32'h1);
        wait_flag(32'h4);
        apb(1'b0, ADDR_STATE, 32'h0);
        chk(rd & 32'h8, 32'h8);
        apb(1'b0, ADDR_CTRL2, 32'h0);
        chk({rd[2:0], scl, sda}, 5'b00010);
        b = 8'($random(seed));
        send({b[6:0], 1'b0}, 1'b0);
        send(8'($random(seed)), 1'b1);
        apb(1'b1, ADDR_CTRL2, 32'h2);
        apb(1'b1, ADDR_BUF, 32'h33);
        wait_flag(32'h1);
        wait_flag(32'h4);
        apb(1'b0, ADDR_CTRL2, 32'h0);
        chk({rd[1], scl, sda}, 3'b010);
        send({b[6:0], 1'b1}, 1'b0);
        apb(1'b1, ADDR_CTRL2, 32'h4);
        wait_flag(32'h1);
        apb(1'b0, ADDR_STATE, 32'h0);
        chk({rd[4], scl, sda}, 3'b111);
        apb(1'b1, ADDR_CTRL2, 32'h1);
        tb_scl <= 1'b1; // scl pulled low before sda falls
        wait_flag(32'h2);
        tb_sda <= 1'b1;
        apb(1'b1, ADDR_CTRL2, 32'h1);
        wait_flag(32'h2);
        apb(1'b0, ADDR_CTRL2, 32'h0);
        chk({rd[0], sda_oe, scl_oe, scl_o, sda_o}, 5'b00000);
        tb_sda <= 1'b0;
        tb_scl <= 1'b0;
        results;
    end
endmodule
`default_nettype wire
